//--- include/apc_cfg.svh
// Register map, field positions, reset values and limits of the auxiliary PLL control
`ifndef APC_CFG_SVH
`define APC_CFG_SVH

// ----------------------------------------
// Register word indices (byte address = index * 4)
// ----------------------------------------
`define APC_IDX_AUX_CTL 6'h00
`define APC_IDX_AUX_FBD 6'h01
`define APC_IDX_MAIN_FBD 6'h02

// ----------------------------------------
// Auxiliary clock control fields
// ----------------------------------------
`define APC_CTL_EN_BIT 15
`define APC_CTL_LOCK_BIT 14
`define APC_CTL_REF_BIT 8
`define APC_CTL_PRE_LSB 0
`define APC_CTL_PRE_MSB 3

// ----------------------------------------
// Reset values and legal ranges
// ----------------------------------------
`define APC_PRE_RESET 4'h1
`define APC_PRE_MIN 4'h1
`define APC_PRE_MAX 4'h8
`define APC_FBD_RESET 8'h96
`define APC_FBD_MIN 8'h10
`define APC_FBD_MAX 8'hc8

`endif

//--- include/apc_pkg.sv
// Types shared by the auxiliary PLL control modules
`default_nettype none
package apc_pkg;
   typedef logic [7:0] apc_fbd_t;
   typedef logic [3:0] apc_pre_t;
   // Start sequencer states, Gray along off -> start -> lock
   typedef enum logic [1:0] {
      APC_SEQ_OFF = 2'b00,
      APC_SEQ_START = 2'b01,
      APC_SEQ_LOCK = 2'b11
   } apc_seq_e;
endpackage
`default_nettype wire

//--- include/apc_ctl_if.sv
// Link between the register file and the PLL start sequencer
`default_nettype none
interface apc_ctl_if;
   logic enable;
   logic clk_req;
   logic pll_locked;
   logic run;
   logic lock_flag;
   modport regs (output enable, output clk_req, output pll_locked, input run, input lock_flag);
   modport seq (input enable, input clk_req, input pll_locked, output run, output lock_flag);
endinterface
`default_nettype wire

//--- rtl/apc_start_seq.sv
// Auxiliary PLL start sequencer: runs the PLL on request and tracks lock
`default_nettype none
module apc_start_seq (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Control link
   apc_ctl_if.seq ctl
);
   import apc_pkg::*;

   apc_seq_e state_q;
   apc_seq_e state_d;
   logic want;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // PLL runs only when enabled and some peripheral requests its clock
   assign want = ctl.enable && ctl.clk_req;

   always_comb begin
      state_d = state_q;
      case (state_q)
         APC_SEQ_OFF: begin
            if (want) begin
               state_d = APC_SEQ_START;
            end
         end
         APC_SEQ_START: begin
            if (!want) begin
               state_d = APC_SEQ_OFF;
            end else if (ctl.pll_locked) begin
               state_d = APC_SEQ_LOCK;
            end
         end
         APC_SEQ_LOCK: begin
            if (!want) begin
               state_d = APC_SEQ_OFF;
            end else if (!ctl.pll_locked) begin
               state_d = APC_SEQ_START;
            end
         end
         default: begin
            state_d = APC_SEQ_OFF;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_q <= APC_SEQ_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   assign ctl.run = (state_q != APC_SEQ_OFF);
   // Lock seen only while running and the loop still reports lock
   assign ctl.lock_flag = (state_q == APC_SEQ_LOCK) && ctl.pll_locked;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_run_on_request: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ctl.run |-> $past(ctl.enable) && $past(ctl.clk_req))
      else $error("PLL runs without enable and clock request");
   chk_start_delay: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (!ctl.run && ctl.enable && ctl.clk_req) |=> ctl.run)
      else $error("PLL did not start one cycle after request");
   chk_lock_track: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (ctl.run && ctl.enable && ctl.clk_req && ctl.pll_locked) ##1
      (ctl.enable && ctl.clk_req && ctl.pll_locked) |-> ctl.lock_flag)
      else $error("Lock flag missing while locked");
endmodule // apc_start_seq
`default_nettype wire

//--- rtl/apc_aux_pll_ctl.sv
// Auxiliary PLL clock configuration registers behind a classic Wishbone slave
`include "apc_cfg.svh"
`default_nettype none
module apc_aux_pll_ctl #(
   parameter int ADR_W = 8
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [ADR_W-1:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Clock system
   input wire logic i_aux_clk_req,
   input wire logic i_aux_pll_locked,
   output logic o_aux_pll_run,
   output logic o_aux_clk_from_pll,
   output logic o_ref_sel_rc,
   output apc_pkg::apc_pre_t o_aux_prescale,
   output apc_pkg::apc_fbd_t o_aux_feedback,
   output apc_pkg::apc_fbd_t o_main_feedback
);
   import apc_pkg::*;

   logic ack_q;
   logic ack_d;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic en_q;
   logic en_d;
   logic ref_q;
   logic ref_d;
   apc_pre_t pre_q;
   apc_pre_t pre_d;
   apc_fbd_t fbd_q;
   apc_fbd_t fbd_d;
   apc_fbd_t mfbd_q;
   apc_fbd_t mfbd_d;
   logic req;
   logic wr;
   logic [5:0] idx;
   logic [15:0] ctl_rd;
   logic [15:0] ctl_new;
   logic [15:0] fbd_new;
   logic [15:0] mfbd_new;

   apc_ctl_if u_link ();

   // ----------------------------------------
   // Start sequencer
   // ----------------------------------------
   assign u_link.enable = en_q;
   assign u_link.clk_req = i_aux_clk_req;
   assign u_link.pll_locked = i_aux_pll_locked;

   apc_start_seq u_seq (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .ctl(u_link.seq)
   );

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   assign req = i_wb_cyc && i_wb_stb;
   // Writes land on the edge where the master sees ack
   assign wr = req && i_wb_we && ack_q;
   assign idx = i_wb_adr[7:2];

   // Merge enabled byte lanes over the current 16-bit register value
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [3:0] sel,
                                         input logic [31:0] dat);
      logic [15:0] res;
      res = old;
      if (sel[0]) begin
         res[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         res[15:8] = dat[15:8];
      end
      return res;
   endfunction

   assign ctl_rd = {en_q, u_link.lock_flag, 5'h00, ref_q, 4'h0, pre_q};
   assign ctl_new = merge(ctl_rd, i_wb_sel, i_wb_dat);
   assign fbd_new = merge({8'h00, fbd_q}, i_wb_sel, i_wb_dat);
   assign mfbd_new = merge({8'h00, mfbd_q}, i_wb_sel, i_wb_dat);

   // ----------------------------------------
   // Register next state
   // ----------------------------------------
   always_comb begin
      ack_d = req && !ack_q;
      rdat_d = rdat_q;
      en_d = en_q;
      ref_d = ref_q;
      pre_d = pre_q;
      fbd_d = fbd_q;
      mfbd_d = mfbd_q;
      if (req && !ack_q) begin
         case (idx)
            `APC_IDX_AUX_CTL: begin
               rdat_d = {16'h0000, ctl_rd};
            end
            `APC_IDX_AUX_FBD: begin
               rdat_d = {24'h000000, fbd_q};
            end
            `APC_IDX_MAIN_FBD: begin
               rdat_d = {24'h000000, mfbd_q};
            end
            default: begin
               rdat_d = 32'h00000000;
            end
         endcase
      end
      if (wr) begin
         case (idx)
            `APC_IDX_AUX_CTL: begin
               // Lock bit is read-only and not taken from the write
               en_d = ctl_new[`APC_CTL_EN_BIT];
               ref_d = ctl_new[`APC_CTL_REF_BIT];
               // Reserved prescale codes are refused, the old code stays
               if (ctl_new[`APC_CTL_PRE_MSB:`APC_CTL_PRE_LSB] >= `APC_PRE_MIN &&
                   ctl_new[`APC_CTL_PRE_MSB:`APC_CTL_PRE_LSB] <= `APC_PRE_MAX) begin
                  pre_d = ctl_new[`APC_CTL_PRE_MSB:`APC_CTL_PRE_LSB];
               end
            end
            `APC_IDX_AUX_FBD: begin
               if (fbd_new[7:0] >= `APC_FBD_MIN && fbd_new[7:0] <= `APC_FBD_MAX) begin
                  fbd_d = fbd_new[7:0];
               end
            end
            `APC_IDX_MAIN_FBD: begin
               // Out-of-range codes are reserved and ignored
               if (mfbd_new[7:0] >= `APC_FBD_MIN && mfbd_new[7:0] <= `APC_FBD_MAX) begin
                  mfbd_d = mfbd_new[7:0];
               end
            end
            default: begin
               mfbd_d = mfbd_q;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h00000000;
         en_q <= 1'b0;
         ref_q <= 1'b0;
         pre_q <= `APC_PRE_RESET;
         fbd_q <= `APC_FBD_RESET;
         mfbd_q <= `APC_FBD_RESET;
      end else begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         en_q <= en_d;
         ref_q <= ref_d;
         pre_q <= pre_d;
         fbd_q <= fbd_d;
         mfbd_q <= mfbd_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_wb_ack = ack_q;
   assign o_wb_dat = rdat_q;
   assign o_aux_pll_run = u_link.run;
   assign o_aux_clk_from_pll = en_q;
   assign o_ref_sel_rc = ref_q;
   assign o_aux_prescale = pre_q;
   assign o_aux_feedback = fbd_q;
   assign o_main_feedback = mfbd_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_ack_single: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (req && !ack_q) |=> ack_q ##1 !ack_q)
      else $error("Ack not a single cycle one cycle after request");
   chk_reset_values: assert property (@(posedge i_clk)
      $past(!i_nrst) |-> (mfbd_q == 8'h96 && fbd_q == 8'h96 && pre_q == 4'h1 && !en_q && !ref_q))
      else $error("Wrong reset values");
   chk_main_fbd_range: assert property (@(posedge i_clk) disable iff (!i_nrst)
      mfbd_q inside {[8'h10:8'hc8]})
      else $error("Main feedback divider out of range");
   chk_aux_fbd_range: assert property (@(posedge i_clk) disable iff (!i_nrst)
      fbd_q >= 8'h10 && fbd_q <= 8'hc8 &&
      ($stable(fbd_q) || $past(wr && idx == `APC_IDX_AUX_FBD)))
      else $error("Aux feedback divider out of range or changed without write");
   chk_prescale_range: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (pre_q != 4'h0) && (pre_q <= 4'h8))
      else $error("Prescale holds a reserved code");
   chk_enable_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (wr && idx == 6'h00 && i_wb_sel[1]) |=> o_aux_clk_from_pll == $past(i_wb_dat[15]))
      else $error("Enable write not applied");
   chk_ref_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (wr && idx == 6'h00 && i_wb_sel[1]) |=> o_ref_sel_rc == $past(i_wb_dat[8]))
      else $error("Reference select write not applied");
   chk_lock_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (req && !ack_q && !i_wb_we && idx == 6'h00) |=> o_wb_dat[14] == $past(u_link.lock_flag))
      else $error("Lock flag read mismatch");
endmodule // apc_aux_pll_ctl
`default_nettype wire

//--- verif/aux_pll_clock_config_tb.sv
// Self-checking bench of the auxiliary PLL clock configuration block
`default_nettype none
module aux_pll_clock_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Stimulus, observation and expectation state
   // ----------------------------------------
   logic i_clk, i_nrst, i_wb_cyc, i_wb_stb, i_wb_we, i_aux_clk_req, i_aux_pll_locked;
   logic [7:0] i_wb_adr;
   logic [3:0] i_wb_sel;
   logic [31:0] i_wb_dat, o_wb_dat;
   logic o_wb_ack, o_aux_pll_run, o_aux_clk_from_pll, o_ref_sel_rc;
   apc_pkg::apc_pre_t o_aux_prescale;
   apc_pkg::apc_fbd_t o_aux_feedback, o_main_feedback;
   logic [15:0] exp_q[$];
   int error_cnt = 0;
   int tests_run = 0;
   int cyc_cnt = 0;
   logic en, ref_rc;
   logic [3:0] pre;
   logic [7:0] fb[1:2];
   logic [7:0] bnd[9] = '{8'h0f, 8'h10, 8'h11, 8'hc7, 8'hc8, 8'hc9, 8'h00, 8'hff, 8'h96};

   apc_aux_pll_ctl #(.ADR_W(8)) dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc),
      .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
      .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
      .i_aux_clk_req(i_aux_clk_req), .i_aux_pll_locked(i_aux_pll_locked),
      .o_aux_pll_run(o_aux_pll_run), .o_aux_clk_from_pll(o_aux_clk_from_pll),
      .o_ref_sel_rc(o_ref_sel_rc), .o_aux_prescale(o_aux_prescale),
      .o_aux_feedback(o_aux_feedback), .o_main_feedback(o_main_feedback));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] s);
      int n;
      n = 0;
      @(posedge i_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= w;
      i_wb_adr <= a;
      i_wb_sel <= s;
      i_wb_dat <= {16'h0000, d};
      do begin
         @(posedge i_clk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 20);
      if (n >= 20)
         check("ack", 1'b0, 1'b1);
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      i_wb_we <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] idx, input logic [15:0] e);
      exp_q.push_back(e);
      wb(1'b0, {idx, 2'b00}, 16'h0000, 4'h3);
   endtask

   task automatic wr_ctl(input logic [15:0] d);
      wb(1'b1, 8'h00, d, 4'h3);
      en = d[15];
      ref_rc = d[8];
      if (d[3:0] >= 4'h1 && d[3:0] <= 4'h8)
         pre = d[3:0];
      #1;
      check("from_pll", o_aux_clk_from_pll, en);
      check("ref_rc", o_ref_sel_rc, ref_rc);
      check("prescale", o_aux_prescale, pre);
      rd(6'h00, {en, 6'h00, ref_rc, 4'h0, pre});
   endtask

   task automatic wr_fb(input logic [5:0] idx, input logic [7:0] v);
      wb(1'b1, {idx, 2'b00}, {8'h00, v}, 4'h3);
      if (v >= 8'h10 && v <= 8'hc8)
         fb[idx] = v;
      #1;
      check("aux fbd", o_aux_feedback, fb[1]);
      check("main fbd", o_main_feedback, fb[2]);
      rd(idx, {8'h00, fb[idx]});
   endtask

   // Read data watcher and hang limit
   always @(posedge i_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (o_wb_ack === 1'b1 && i_wb_we === 1'b0)
         check("read", o_wb_dat, exp_q.size() ? {16'h0, exp_q.pop_front()} : 32'hx);
      if (cyc_cnt > 5000) begin
         error_cnt++;
         wrap_up();
      end
   end

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {i_nrst, i_wb_cyc, i_wb_stb, i_wb_we, i_aux_clk_req, i_aux_pll_locked} = '0;
      {i_wb_adr, i_wb_sel, i_wb_dat} = '0;
      {en, ref_rc, pre, fb[1], fb[2]} = {2'b00, 4'h1, 8'h96, 8'h96};
      void'($urandom(80282));
      repeat (8) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      #1;
      check("run", o_aux_pll_run, 1'b0);
      check("aux fbd", o_aux_feedback, 8'h96);
      check("main fbd", o_main_feedback, 8'h96);
      check("prescale", o_aux_prescale, 4'h1);
      check("ref_rc", o_ref_sel_rc, 1'b0);
      check("from_pll", o_aux_clk_from_pll, 1'b0);
      rd(6'h00, 16'h0001);
      rd(6'h01, 16'h0096);
      rd(6'h02, 16'h0096);
      for (int c = 0; c < 16; c++)
         wr_ctl({c[0], c[2], 5'h00, c[1], 4'h0, c[3:0]});
      foreach (bnd[i]) begin
         wr_fb(6'h01, bnd[i]);
         wr_fb(6'h02, bnd[i]);
      end
      repeat (20)
         wr_fb(6'h01 + 6'($urandom_range(1)), 8'($urandom));
      // Low byte lane only: enable and reference bits must stay
      wb(1'b1, 8'h00, 16'h0105, 4'h1);
      pre = 4'h5;
      rd(6'h00, {en, 6'h00, ref_rc, 4'h0, pre});
      wb(1'b1, 8'h0c, 16'hffff, 4'h3);
      rd(6'h03, 16'h0000);
      rd(6'h01, {8'h00, fb[1]});
      wr_ctl(16'h8001);
      i_aux_pll_locked <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      check("run no request", o_aux_pll_run, 1'b0);
      rd(6'h00, 16'h8001);
      i_aux_clk_req <= 1'b1;
      #1;
      check("run early", o_aux_pll_run, 1'b0);
      @(posedge i_clk);
      #1;
      check("run", o_aux_pll_run, 1'b1);
      repeat (3) @(posedge i_clk);
      rd(6'h00, 16'hc001);
      i_aux_pll_locked <= 1'b0;
      repeat (2) @(posedge i_clk);
      rd(6'h00, 16'h8001);
      i_aux_pll_locked <= 1'b1;
      i_aux_clk_req <= 1'b0;
      @(posedge i_clk);
      #1;
      check("run drop", o_aux_pll_run, 1'b0);
      rd(6'h00, 16'h8001);
      wr_ctl(16'h0001);
      i_aux_clk_req <= 1'b1;
      repeat (3) @(posedge i_clk);
      #1;
      check("run disabled", o_aux_pll_run, 1'b0);
      rd(6'h00, 16'h0001);
      wrap_up();
   end
endmodule // aux_pll_clock_config_tb
`default_nettype wire
